/* src/ccc_top.sv */
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "ccc_map.svh"
module ccc_top (
   // clock and reset
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   // apb slave
   input  wire logic [7:0]            paddr,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   // correlator events
   input  wire logic [11:0]           integration_end,
   input  wire logic                  measurement_epoch_strobe,
   input  wire logic                  swap_early_strobe,
   input  wire logic [11:0]           epoch_count_loaded,
   input  wire logic [11:0]           epoch20_increment,
   input  wire logic [11:0]           chip_advance,
   input  wire logic [11:0][10:0]     code_phase,
   // channel outputs
   output ccc_pkg::ccc_ctl_s [11:0]   chan_ctl,
   output logic      [11:0]           preset_mode,
   output logic      [11:0]           dither_late,
   output ccc_pkg::ccc_codes_s [11:0] chan_codes,
   output logic      [11:0]           channel_enable,
   output logic                       software_master_reset
);
   ccc_pkg::ccc_top_s s_r;
   ccc_pkg::ccc_top_s s_nxt;
   logic              setup;
   logic              acc;
   logic              ph_ok;
   logic [3:0]        ph_ix;
   logic [11:0]       ctl_wr;

   function automatic logic win(input logic [7:0] a, input logic [1:0] blk);
      win = (a[7:6] == blk) && (a[1:0] == 2'b00) && (a[5:2] < `CCC_NCH_IX);
   endfunction : win

   function automatic logic [11:0] wmask(input logic [7:0] a, input logic [11:0] msel);
      wmask = 12'h000;
      if (win(a, `CCC_BLK_CTL)) begin
         wmask = 12'h001 << a[5:2];
      end else if (a == `CCC_A_CTL_MULTI) begin
         wmask = msel;
      end else if (a == `CCC_A_CTL_ALL) begin
         wmask = 12'hfff;
      end
   endfunction : wmask

   function automatic logic mapped(input logic [7:0] a);
      mapped = win(a, `CCC_BLK_CTL) || win(a, `CCC_BLK_PH) ||
               (a == `CCC_A_CTL_MULTI) || (a == `CCC_A_CTL_ALL) ||
               (a == `CCC_A_MSEL) || (a == `CCC_A_SWRST) ||
               (a == `CCC_A_STATUS) || (a == `CCC_A_CHEN) ||
               (a == `CCC_A_DITHER);
   endfunction : mapped

   assign setup = psel && !penable;
   assign acc = psel && penable;
   assign ph_ok = win(paddr, `CCC_BLK_PH);
   assign ph_ix = paddr[5:2];
   // control words are write-only, aliases fan out
   assign ctl_wr = (acc && pwrite) ? wmask(paddr, s_r.msel) : 12'h000;

   always_comb begin
      logic [11:0] missed_set;
      missed_set = 12'h000;
      s_nxt = s_r;
      s_nxt.swrst = 1'b0;
      // read data and error sampled in setup
      if (setup) begin
         s_nxt.err = !mapped(paddr);
         s_nxt.rdata = 16'h0000;
         if (paddr == `CCC_A_STATUS) begin
            s_nxt.rdata = {2'b00, s_r.newm, s_r.swap, s_r.missed};
         end else if (paddr == `CCC_A_CHEN) begin
            s_nxt.rdata = {4'h0, s_r.chen};
         end else if (paddr == `CCC_A_DITHER) begin
            s_nxt.rdata = {4'h0, dither_late};
         end else if (ph_ok) begin
            s_nxt.rdata = {5'h00, s_r.cap[ph_ix]};
         end
      end
      if (acc && !pwrite) begin
         if (paddr == `CCC_A_STATUS) begin
            // clear only what the read returned
            s_nxt.newm = s_r.newm & ~s_r.rdata[`CCC_F_NEWM];
            s_nxt.swap = s_r.swap & ~s_r.rdata[`CCC_F_SWAP];
            s_nxt.missed = s_r.missed & ~s_r.rdata[11:0];
         end else if (ph_ok) begin
            missed_set[ph_ix] = s_r.overrun[ph_ix];
            s_nxt.overrun[ph_ix] = 1'b0;
            s_nxt.unread[ph_ix] = 1'b0;
         end
      end
      if (acc && pwrite) begin
         if (paddr == `CCC_A_MSEL) begin
            s_nxt.msel = pwdata[11:0];
         end else if (paddr == `CCC_A_SWRST) begin
            s_nxt.swrst = pwdata[0];
         end else if (paddr == `CCC_A_CHEN) begin
            s_nxt.chen = pwdata[11:0];
         end
      end
      if (measurement_epoch_strobe) begin
         s_nxt.cap = code_phase;
         s_nxt.overrun = s_nxt.overrun | s_nxt.unread;
         s_nxt.unread = 12'hfff;
         s_nxt.newm = 1'b1;
         s_nxt.swap = 1'b1;
      end
      if (swap_early_strobe) begin
         s_nxt.swap = 1'b1;
      end
      // set wins over clear, disable clears
      s_nxt.missed = (s_nxt.missed & s_r.chen) | missed_set;
      if (s_r.swrst) begin
         s_nxt.missed = 12'h000;
         s_nxt.unread = 12'h000;
         s_nxt.overrun = 12'h000;
         s_nxt.msel = 12'h000;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '0;
         s_r.chen <= `CCC_CHEN_RESET;
      end else begin
         s_r <= s_nxt;
      end
   end

   // channels
   for (genvar i = 0; i < 12; i++) begin : g_ch
      ccc_chan u_chan (
         .clk          (pclk),
         .rst_n        (presetn),
         .sw_reset     (s_r.swrst),
         .wr           (ctl_wr[i]),
         .wdata        (pwdata[15:0]),
         .integ_end    (integration_end[i]),
         .epoch_strobe (measurement_epoch_strobe),
         .epoch_loaded (epoch_count_loaded[i]),
         .epoch20_inc  (epoch20_increment[i]),
         .chip_adv     (chip_advance[i]),
         .act_ctl      (chan_ctl[i]),
         .preset_mode  (preset_mode[i]),
         .dither_late  (dither_late[i]),
         .codes        (chan_codes[i])
      );
   end

   assign prdata = {16'h0000, s_r.rdata};
   assign pready = 1'b1;
   assign pslverr = acc && s_r.err;
   assign channel_enable = s_r.chen;
   assign software_master_reset = s_r.swrst;
endmodule : ccc_top
`default_nettype wire

/* src/ccc_map.svh */
`ifndef CCC_MAP_SVH
`define CCC_MAP_SVH
// register byte addresses
`define CCC_A_CTL_MULTI 8'h30
`define CCC_A_CTL_ALL   8'h34
`define CCC_A_MSEL      8'h38
`define CCC_A_SWRST     8'h3c
`define CCC_A_STATUS    8'h40
`define CCC_A_CHEN      8'h44
`define CCC_A_DITHER    8'h48
// per-channel blocks, address bits 7:6
`define CCC_BLK_CTL     2'b00
`define CCC_BLK_PH      2'b10
`define CCC_NCH_IX      4'hc
// control word fields
`define CCC_F_CONST     15
`define CCC_F_MODE      12
`define CCC_F_SEED_HI   9
// status fields
`define CCC_F_NEWM      13
`define CCC_F_SWAP      12
// reset values
`define CCC_CTL_RESET   15'h4000
`define CCC_CHEN_RESET  12'hfff
// code generator
`define CCC_GPS_LAST    10'h3fe
`define CCC_GLO_LAST    10'h1fe
`define CCC_G1_INIT     10'h3ff
`define CCC_GLO_INIT    9'h1ff
`define CCC_EPL_INIT    3'b111
`endif

/* src/ccc_pkg.sv */
package ccc_pkg;
   typedef enum logic [1:0] {CCC_TRK_EARLY, CCC_TRK_LATE, CCC_TRK_DITHER, CCC_TRK_EML} ccc_track_e;
   typedef struct packed {
      logic       constellation_select;
      ccc_track_e track_sel;
      logic       code_force_test;
      logic       input_pair_select;
      logic [9:0] second_register_seed;
   } ccc_ctl_s;
   typedef struct packed {
      logic       prompt;
      logic       early;
      logic       late;
      logic [1:0] track;
   } ccc_codes_s;
   typedef struct packed {
      ccc_ctl_s   pend;
      ccc_ctl_s   act;
      logic       preset;
      logic       armed;
      logic       dith;
      logic [9:0] g1;
      logic [9:0] g2;
      logic [8:0] glo;
      logic [9:0] cnt;
      logic [2:0] epl;
   } ccc_chan_s;
   typedef struct packed {
      logic              newm;
      logic              swap;
      logic [11:0]       missed;
      logic [11:0]       unread;
      logic [11:0]       overrun;
      logic [11:0]       msel;
      logic [11:0]       chen;
      logic              swrst;
      logic [15:0]       rdata;
      logic              err;
      logic [11:0][10:0] cap;
   } ccc_top_s;
endpackage : ccc_pkg

/* src/ccc_chan.sv */
`timescale 1ns/10ps
`default_nettype none
`include "ccc_map.svh"
module ccc_chan (
   // clock and reset
   input  wire logic                clk,
   input  wire logic                rst_n,
   input  wire logic                sw_reset,
   // control word write
   input  wire logic                wr,
   input  wire logic [15:0]         wdata,
   // timing events
   input  wire logic                integ_end,
   input  wire logic                epoch_strobe,
   input  wire logic                epoch_loaded,
   input  wire logic                epoch20_inc,
   input  wire logic                chip_adv,
   // state out
   output ccc_pkg::ccc_ctl_s        act_ctl,
   output logic                     preset_mode,
   output logic                     dither_late,
   output ccc_pkg::ccc_codes_s      codes
);
   ccc_pkg::ccc_chan_s s_r;
   ccc_pkg::ccc_chan_s s_nxt;
   logic               e;
   logic               l;
   logic               p;

   always_comb begin
      logic apply;
      logic chip;
      apply = s_r.preset ? epoch_strobe : integ_end;
      chip = s_r.act.constellation_select ? (s_r.g1[9] ^ s_r.g2[9]) : s_r.glo[8];
      s_nxt = s_r;
      if (epoch_loaded && s_r.preset) begin
         s_nxt.armed = 1'b1;
      end
      if (epoch20_inc) begin
         s_nxt.dith = ~s_r.dith;
      end
      if (apply) begin
         s_nxt.act = s_r.pend;
         s_nxt.g1 = `CCC_G1_INIT;
         s_nxt.g2 = s_r.pend.second_register_seed;
         s_nxt.glo = `CCC_GLO_INIT;
         s_nxt.cnt = 10'h000;
         s_nxt.epl = `CCC_EPL_INIT;
      end else if (chip_adv) begin
         s_nxt.epl = {s_r.epl[1:0], chip};
         s_nxt.g1 = {s_r.g1[8:0], s_r.g1[2] ^ s_r.g1[9]};
         if (s_r.g2 != 10'h000) begin
            s_nxt.g2 = {s_r.g2[8:0], ^{s_r.g2[1], s_r.g2[2], s_r.g2[5], s_r.g2[7], s_r.g2[8], s_r.g2[9]}};
         end
         s_nxt.glo = {s_r.glo[7:0], s_r.glo[4] ^ s_r.glo[8]};
         s_nxt.cnt = s_r.cnt + 10'h001;
         if (s_r.cnt == (s_r.act.constellation_select ? `CCC_GPS_LAST : `CCC_GLO_LAST)) begin
            s_nxt.g1 = `CCC_G1_INIT;
            s_nxt.g2 = s_r.act.second_register_seed;
            s_nxt.glo = `CCC_GLO_INIT;
            s_nxt.cnt = 10'h000;
         end
      end
      if (s_r.preset && s_r.armed && epoch_strobe) begin
         s_nxt.preset = 1'b0;
         s_nxt.armed = 1'b0;
      end
      if (wr) begin
         s_nxt.pend = ccc_pkg::ccc_ctl_s'({wdata[`CCC_F_CONST:`CCC_F_MODE+1], wdata[`CCC_F_MODE-1:0]});
         s_nxt.preset = wdata[`CCC_F_MODE];
         s_nxt.armed = 1'b0;
      end
      if (sw_reset) begin
         s_nxt = '0;
         s_nxt.pend = ccc_pkg::ccc_ctl_s'(`CCC_CTL_RESET);
         s_nxt.act = ccc_pkg::ccc_ctl_s'(`CCC_CTL_RESET);
         s_nxt.g1 = `CCC_G1_INIT;
         s_nxt.glo = `CCC_GLO_INIT;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= '0;
         s_r.pend <= ccc_pkg::ccc_ctl_s'(`CCC_CTL_RESET);
         s_r.act <= ccc_pkg::ccc_ctl_s'(`CCC_CTL_RESET);
         s_r.g1 <= `CCC_G1_INIT;
         s_r.glo <= `CCC_GLO_INIT;
      end else begin
         s_r <= s_nxt;
      end
   end

   // code force holds mixers transparent
   assign e = s_r.epl[0] | s_r.act.code_force_test;
   assign p = s_r.epl[1] | s_r.act.code_force_test;
   assign l = s_r.epl[2] | s_r.act.code_force_test;

   always_comb begin
      logic t;
      t = e;
      codes.prompt = p;
      codes.early = e;
      codes.late = l;
      case (s_r.act.track_sel)
         ccc_pkg::CCC_TRK_EARLY: t = e;
         ccc_pkg::CCC_TRK_LATE: t = l;
         ccc_pkg::CCC_TRK_DITHER: t = s_r.dith ? l : e;
         default: t = e;
      endcase
      // +1 as 01, -1 as 11, 0 as 00
      codes.track = t ? 2'b01 : 2'b11;
      if (s_r.act.track_sel == ccc_pkg::CCC_TRK_EML) begin
         codes.track = (s_r.act.code_force_test || (e == l)) ? 2'b00 : (e ? 2'b01 : 2'b11);
      end
   end

   assign act_ctl = s_r.act;
   assign preset_mode = s_r.preset;
   assign dither_late = s_r.dith;
endmodule : ccc_chan
`default_nettype wire

/* dv/ccc_top_props.sv */
`timescale 1ns/10ps
`default_nettype none
module ccc_top_props (
   // clock and reset
   input wire logic                       pclk,
   input wire logic                       presetn,
   // apb
   input wire logic [7:0]                 paddr,
   input wire logic                       psel,
   input wire logic                       penable,
   input wire logic                       pwrite,
   input wire logic [31:0]                pwdata,
   input wire logic [31:0]                prdata,
   input wire logic                       pready,
   // events
   input wire logic [11:0]                integration_end,
   input wire logic                       measurement_epoch_strobe,
   input wire logic                       swap_early_strobe,
   input wire logic [11:0]                epoch20_increment,
   // channel state
   input wire ccc_pkg::ccc_ctl_s [11:0]   chan_ctl,
   input wire logic [11:0]                preset_mode,
   input wire logic [11:0]                dither_late,
   input wire ccc_pkg::ccc_codes_s [11:0] chan_codes,
   input wire logic                       software_master_reset
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_stat_setup;
      psel && !penable && !pwrite && paddr == 8'h40;
   endsequence
   sequence s_new_meas;
      measurement_epoch_strobe ##[1:3] s_stat_setup;
   endsequence
   sequence s_early_swap;
      swap_early_strobe ##[1:3] s_stat_setup;
   endsequence
   a_write_any: assert property (psel && penable |-> pready)
      else $error("access not accepted");
   a_ctl_hold: assert property (
      !integration_end[0] && !measurement_epoch_strobe && !software_master_reset |=> $stable(chan_ctl[0]))
      else $error("control word changed without event");
   a_mode_write: assert property (
      psel && penable && pwrite && paddr == 8'h04 && pwdata[12] |=> preset_mode[1])
      else $error("mode bit not applied at once");
   a_force_codes: assert property (
      chan_ctl[0].code_force_test |-> chan_codes[0].prompt && chan_codes[0].early && chan_codes[0].late &&
      chan_codes[0].track == ((chan_ctl[0].track_sel == ccc_pkg::CCC_TRK_EML) ? 2'b00 : 2'b01))
      else $error("forced codes wrong");
   a_track_early: assert property (
      !chan_ctl[0].code_force_test && chan_ctl[0].track_sel == ccc_pkg::CCC_TRK_EARLY
      |-> chan_codes[0].track == {!chan_codes[0].early, 1'b1})
      else $error("tracking arm not early");
   a_eml_half: assert property (
      !chan_ctl[0].code_force_test && chan_ctl[0].track_sel == ccc_pkg::CCC_TRK_EML
      |-> chan_codes[0].track == ((chan_codes[0].early == chan_codes[0].late) ? 2'b00 : {!chan_codes[0].early, 1'b1}))
      else $error("difference code wrong");
   a_dither_toggle: assert property (
      epoch20_increment[0] && !software_master_reset |=> dither_late[0] != $past(dither_late[0]))
      else $error("dither state did not toggle");
   a_new_meas: assert property (s_new_meas |=> prdata[13])
      else $error("new measurement flag missing");
   a_swap_flag: assert property (s_early_swap |=> prdata[12])
      else $error("swap flag missing");
endmodule : ccc_top_props
bind ccc_top ccc_top_props i_ccc_top_props (
   .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
   .integration_end, .measurement_epoch_strobe, .swap_early_strobe, .epoch20_increment,
   .chan_ctl, .preset_mode, .dither_late, .chan_codes, .software_master_reset
);
`default_nettype wire

/* dv/ccc_host.sv */
`timescale 1ns/10ps
`default_nettype none
module ccc_host (
   // clock
   input  wire logic        pclk,
   // apb master
   output logic      [7:0]  paddr,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic      [31:0] pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   initial begin
      paddr = 8'h00;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      pwdata = 32'h0;
   end
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e, output logic t);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      t = (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~d;
      #1;
   endtask : xfer
endmodule : ccc_host
`default_nettype wire

/* dv/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin \
   n_compared++; \
   if ((g) !== (e)) begin \
      n_errors++; \
      $display("BAD %s exp %h got %h", nm, e, g); \
   end \
end
module tb_top;
   logic                       pclk, presetn, psel, penable, pwrite, pready, pslverr, er, swrst;
   logic                       measurement_epoch_strobe, swap_early_strobe;
   logic [7:0]                 paddr;
   logic [31:0]                pwdata, prdata, q;
   logic [11:0]                integration_end, epoch_count_loaded, epoch20_increment, chip_advance;
   logic [11:0]                preset_mode, dither_late, channel_enable;
   logic [11:0][10:0]          code_phase;
   ccc_pkg::ccc_ctl_s [11:0]   chan_ctl;
   ccc_pkg::ccc_codes_s [11:0] chan_codes;
   int                         n_errors = 0;
   int                         n_compared = 0;
   ccc_top i_ccc_top (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
      .pslverr, .integration_end, .measurement_epoch_strobe, .swap_early_strobe, .epoch_count_loaded,
      .epoch20_increment, .chip_advance, .code_phase, .chan_ctl, .preset_mode, .dither_late,
      .chan_codes, .channel_enable, .software_master_reset(swrst));
   ccc_host i_ccc_host (.pclk, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr);
   task automatic finish_test;
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : finish_test
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      logic t;
      i_ccc_host.xfer(w, a, d, q, er, t);
      if (t) begin
         n_errors++;
         finish_test();
      end
   endtask : bus
   task automatic pulse(input int k, input logic [11:0] m);
      @(posedge pclk);
      case (k)
         0: integration_end <= m;
         1: measurement_epoch_strobe <= 1'b1;
         2: swap_early_strobe <= 1'b1;
         3: epoch_count_loaded <= m;
         4: epoch20_increment <= m;
         default: chip_advance <= m;
      endcase
      @(posedge pclk);
      integration_end <= '0;
      measurement_epoch_strobe <= 1'b0;
      swap_early_strobe <= 1'b0;
      epoch_count_loaded <= '0;
      epoch20_increment <= '0;
      chip_advance <= '0;
      #1;
   endtask : pulse
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   initial begin
      presetn = 1'b0;
      integration_end = '0;
      measurement_epoch_strobe = 1'b0;
      swap_early_strobe = 1'b0;
      epoch_count_loaded = '0;
      epoch20_increment = '0;
      chip_advance = '0;
      code_phase = {12{11'h5a5}};
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      #1;
      `CHK("ctl0", 15'h4000, chan_ctl[0])
      `CHK("codes0", 5'b00011, chan_codes[0])
      `CHK("chen0", 12'hfff, channel_enable)
      bus(0, 8'h40, 0);
      `CHK("status", 32'h0, q)
      bus(1, 8'h0c, 32'h83f6);
      pulse(5, 12'hfff);
      `CHK("g1out", 5'b01001, chan_codes[0])
      `CHK("hold3", 15'h4000, chan_ctl[3])
      pulse(0, 12'h008);
      `CHK("ctl3", 15'h43f6, chan_ctl[3])
      `CHK("first", 1'b1, chan_codes[3].prompt)
      bus(1, 8'h04, 32'h9058);
      `CHK("mode1", 1'b1, preset_mode[1])
      pulse(0, 12'h002);
      `CHK("pend1", 15'h4000, chan_ctl[1])
      pulse(1, 0);
      `CHK("ctl1", 15'h4058, chan_ctl[1])
      `CHK("unarmed", 1'b1, preset_mode[1])
      pulse(3, 12'h002);
      pulse(1, 0);
      `CHK("done1", 1'b0, preset_mode[1])
      bus(0, 8'h40, 0);
      `CHK("status", 32'h3000, q)
      bus(0, 8'h40, 0);
      `CHK("cleared", 32'h0, q)
      pulse(2, 0);
      bus(0, 8'h40, 0);
      `CHK("swap", 32'h1000, q)
      for (int r = 0; r < 2; r++) begin
         pulse(1, 0);
         pulse(1, 0);
         bus(0, 8'h88, 0);
         `CHK("phase2", 32'h5a5, q)
         if (r == 1) begin
            bus(1, 8'h3c, 32'h1);
            `CHK("swrst", 1'b1, swrst)
            repeat (3) @(posedge pclk);
         end
         bus(0, 8'h40, 0);
         `CHK("missed", (r == 0) ? 32'h3004 : 32'h3000, q)
      end
      pulse(1, 0);
      pulse(1, 0);
      bus(0, 8'h88, 0);
      bus(1, 8'h44, 32'hffb);
      bus(0, 8'h44, 0);
      `CHK("chenrd", 32'hffb, q)
      `CHK("chen", 12'hffb, channel_enable)
      bus(0, 8'h40, 0);
      `CHK("disabled", 32'h3000, q)
      bus(1, 8'h44, 32'hfff);
      bus(0, 8'h4c, 0);
      `CHK("unmapped", 33'h100000000, {er, q})
      for (int m = 0; m < 4; m++) begin
         bus(1, 8'h34, {16'h0, 1'b1, m[1:0], 2'b00, m[0], 10'h0});
         pulse(0, 12'hfff);
         pulse(4, 12'h001);
         `CHK("track", m[1:0], chan_ctl[11].track_sel)
         `CHK("pair", m[0], chan_ctl[11].input_pair_select)
         bus(0, 8'h48, 0);
         `CHK("dithreg", {31'h0, !m[0]}, q)
      end
      bus(1, 8'h34, 32'h8800);
      pulse(0, 12'hfff);
      `CHK("force5", 5'b11101, chan_codes[5])
      bus(1, 8'h38, 32'h100);
      bus(1, 8'h30, 32'h0);
      pulse(0, 12'hfff);
      `CHK("ctl8", 15'h0000, chan_ctl[8])
      `CHK("ctl9", 15'h4800, chan_ctl[9])
      finish_test();
   end
endmodule : tb_top
`default_nettype wire
